// File: design/flash_fetch_pkg.sv
// Shared constants, types and states of the serial flash fetch controller
package flash_fetch_pkg;
    // Timing
    localparam int CLK_HZ = 25_000_000;
    localparam int SCK_SLOW_HZ = 30_000_000;
    localparam int SCK_FAST_HZ = 60_000_000;
    // Synchroniser latency plus one cycle of margin
    localparam int SYNC_MARGIN_CYC = 5;
    localparam int RAW_FAST_HALF_CYC = (CLK_HZ + 2 * SCK_FAST_HZ - 1) / (2 * SCK_FAST_HZ);
    localparam int FAST_HALF_INT = (RAW_FAST_HALF_CYC > SYNC_MARGIN_CYC) ? RAW_FAST_HALF_CYC : SYNC_MARGIN_CYC;
    localparam logic [7:0] HALF_FAST_CYC = 8'(FAST_HALF_INT);
    localparam logic [7:0] HALF_SLOW_CYC = 8'(FAST_HALF_INT * SCK_FAST_HZ / SCK_SLOW_HZ);
    localparam logic [2:0] STRAP_SETTLE_CYC = 3'h4;

    // Opcodes and transfer lengths
    localparam logic [7:0] OP_FAST_READ = 8'h0B;
    localparam logic [7:0] OP_DUAL_READ = 8'h3B;
    localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
    localparam logic [7:0] OP_SMALL_BLOCK_ERASE = 8'h52;
    localparam logic [7:0] OP_LARGE_BLOCK_ERASE = 8'hD8;
    localparam logic [7:0] OP_BYTE_PROGRAM = 8'h02;
    localparam logic [7:0] OP_IDENT_READ = 8'h9F;
    localparam logic [7:0] LEN_ERASE = 8'h04;
    localparam logic [7:0] LEN_PROGRAM = 8'h05;
    localparam logic [7:0] LEN_SINGLE = 8'h01;
    localparam logic [7:0] LEN_IDENT = 8'h04;

    // Frame layout
    localparam logic [5:0] HDR_BITS = 6'h28;
    localparam int DUAL_ADDR_BITS = 17;
    localparam logic [7:0] DUMMY_BYTE = 8'h00;
    localparam logic FILL_BIT = 1'b1;
    localparam logic [7:0] CMD_BYTES = 8'h08;
    localparam logic [2:0] SINGLE_LAST_BIT = 3'h7;
    localparam logic [2:0] DUAL_LAST_BIT = 3'h3;

    // Boot signature "2DFU", byte 0 at the lowest address
    localparam logic [23:0] SIG_ADDR = 24'h00FFFA;
    localparam logic [23:0] BOOT_START_ADDR = 24'h000000;
    localparam logic [1:0] SIG_LAST = 2'h3;
    localparam logic [3:0][7:0] BOOT_SIG = {8'h55, 8'h46, 8'h44, 8'h32};

    typedef logic [7:0][7:0] byte_buf_t;

    typedef struct packed {
        logic sck;
        logic csN;
        logic dataOut;
        logic dataOutOe;
    } flash_pins_s;

    typedef struct packed {
        logic ready;
        logic [7:0] data;
    } fetch_rsp_s;

    typedef enum logic [5:0] {
        S_IDLE = 6'h01,
        S_HDR = 6'h02,
        S_DATA = 6'h04,
        S_OPEN = 6'h08,
        S_MAN = 6'h10,
        S_END = 6'h20
    } seq_state_e;
endpackage

// File: design/pin_sync.sv
// Three-stage synchroniser that passes a bit once its second and third stages agree
`timescale 1ns/100ps
module pin_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
    logic [W-1:0] stage3;
    wire [W-1:0] agree = ~(stage2 ^ stage3);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            dout <= '0;
        end else begin
            stage1 <= din;
            stage2 <= stage1;
            stage3 <= stage2;
            dout <= (agree & stage3) | (~agree & dout);
        end
    end
endmodule

// File: design/serial_flash_fetch_controller.sv
// Serial flash fetch controller: boot check, fast reads, fetch cache and manual commands
// Behaviour
// (RULE1) After reset read the four bytes at 0xFFFA; on signature match enable external code.
// (RULE2) Port enabled out of reset; disabled while the port-disable bit is set.
// (RULE3) Single-lane read: select low, send 0x0B, 24-bit address, dummy byte, read 8 clocks.
// (RULE4) After a full data byte arrives, pulse ready and hand over that byte.
// (RULE5) While each fetch address is the previous plus one, keep burst open.
// (RULE6) A non-sequential fetch address ends the burst with select high.
// (RULE7) Dual mode sends the programmed opcode, address bits 23..17 forced zero.
// (RULE8) Dual mode reads each byte in four clocks, two bits per clock.
// (RULE9) 32-byte cache: base set on jump, length grows, base slides past 32.
// (RULE10) Fetch hitting the cache returns next clock with no flash access.
// (RULE11) Manual command: 8-byte buffers, byte length, go bit gives length times 8 clocks.
// (RULE12) After the first command byte, the input line fills the response buffer.
// (RULE13) Command bytes beyond the eight buffered ones are sent as filler.
// (RULE14) Select goes high once the programmed byte count has been transferred.
// (RULE15) Erases are opcode 0x20, 0x52 or 0xD8 plus address, length four.
// (RULE16) Byte program is 0x02, address and one data byte, length five.
// (RULE17) Single-opcode commands use buffer byte zero with length one.
// (RULE18) Identification read is 0x9F, length four, three bytes returned.
// (RULE19) Flash clock is the slow rate with strap low, fast rate with strap high.
// (RULE20) Go bit clears itself when select rises at the end of a command.
// (RULE21) The flash answers after command, address and dummy, in the requested lane form.
`timescale 1ns/100ps
module serial_flash_fetch_controller
    import flash_fetch_pkg::*;
#(
    parameter int CACHE_DEPTH = 32
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic fetchReq,
    input wire logic [23:0] fetchAddr,
    output fetch_rsp_s fetchRsp,
    input wire logic dualMode,
    input wire logic [7:0] fastReadOpcode,
    input wire logic portDisable,
    input wire logic flashSpeedStrap,
    input wire logic goSet,
    input wire logic [7:0] commandLength,
    input wire byte_buf_t commandBuffer,
    output byte_buf_t responseBuffer,
    output logic goBusy,
    output logic serialPortEnabled,
    output logic bootDone,
    output logic externalBoot,
    output flash_pins_s flashPins,
    input wire logic flashDataOutIn,
    input wire logic serialInLine
);
    localparam int CIDX = $clog2(CACHE_DEPTH);
    localparam logic [CIDX:0] CACHE_FULL = (CIDX + 1)'(CACHE_DEPTH);
    seq_state_e state;
    flash_pins_s pins;
    fetch_rsp_s rsp;
    byte_buf_t resp;
    logic [2:0] syncIn, strapCnt;
    logic strapTaken, fastClk, dualRun, jumpRun, pend, bootWait, portEn, goFlag;
    logic [7:0] halfCnt, shIn;
    logic [10:0] bitCnt;
    logic [39:0] shOut;
    logic [23:0] curAddr, pendAddr, cacheBase;
    logic [7:0] cacheMem [CACHE_DEPTH];
    logic [CIDX:0] cacheLen;
    logic [1:0] bootIdx;
    pin_sync #(.W(3)) uSync (
        .clk(clk),
        .rst_n(rst_n),
        .din({serialInLine, flashDataOutIn, flashSpeedStrap}),
        .dout(syncIn)
    );
    wire inMiso = syncIn[2];
    wire inIo0 = syncIn[1];
    wire strapSync = syncIn[0];
    // Serial clock divider
    wire [7:0] halfLoad = fastClk ? (HALF_FAST_CYC - 8'h01) : (HALF_SLOW_CYC - 8'h01); // [RULE19]
    wire tick = (halfCnt == 8'h00);
    wire rise = tick & ~pins.sck;
    wire fall = tick & pins.sck;
    // Request source: boot reads first, then the processor
    wire booting = strapTaken & ~bootDone;
    wire bootReq = booting & portEn & ~bootWait & ~pend & (state == S_IDLE || state == S_OPEN);
    wire reqValid = booting ? bootReq : (fetchReq & bootDone & portEn);
    wire [23:0] reqAddr = booting ? (SIG_ADDR + {22'h0, bootIdx}) : fetchAddr;
    wire [23:0] cacheOff = reqAddr - cacheBase;
    wire hit = reqValid & (cacheOff < {{(23 - CIDX){1'b0}}, cacheLen}); // [RULE10]
    // Burst decisions
    wire seqNext = pend & (pendAddr == curAddr + 24'h000001); // [RULE5]
    wire startBurst = (state == S_IDLE) & pend & portEn;
    wire contBurst = (state == S_OPEN) & portEn & ~hit & seqNext;
    wire dropPend = (state == S_IDLE) & ~portEn;
    wire [7:0] hdrOpcode = dualMode ? fastReadOpcode : OP_FAST_READ; // [RULE3] [RULE7]
    wire [23:0] hdrAddr = dualMode ? {7'h00, pendAddr[DUAL_ADDR_BITS-1:0]} : pendAddr; // [RULE7]
    wire [39:0] hdrWord = {hdrOpcode, hdrAddr, DUMMY_BYTE};
    wire [7:0] sampled = dualRun ? {shIn[5:0], inMiso, inIo0} : {shIn[6:0], inMiso}; // [RULE8]
    wire [2:0] lastBit = dualRun ? DUAL_LAST_BIT : SINGLE_LAST_BIT;
    wire byteDone = (state == S_DATA) & fall & (bitCnt[2:0] == lastBit);
    // Manual command sequencing
    wire [10:0] manTotal = {commandLength, 3'b000}; // [RULE11]
    wire [10:0] nextIdx = bitCnt + 11'h001;
    wire [7:0] nextByte = nextIdx[10:3];
    wire manBit = (nextByte < CMD_BYTES) ? commandBuffer[nextByte[2:0]][~nextIdx[2:0]] : FILL_BIT; // [RULE13]
    wire manStart = (state == S_IDLE) & ~pend & portEn & goFlag & (commandLength != 8'h00);
    wire manEnd = (state == S_MAN) & fall & (nextIdx == manTotal); // [RULE14]
    wire goDrop = (state == S_IDLE) & ~pend & goFlag & (~portEn | (commandLength == 8'h00));
    wire [7:0] respIdx = bitCnt[10:3] - 8'h01;
    wire respWrite = (state == S_MAN) & rise & (bitCnt >= 11'h008) & (bitCnt[2:0] == 3'h7) &
        (respIdx < CMD_BYTES); // [RULE12]
    assign fetchRsp = rsp;
    assign flashPins = pins;
    assign responseBuffer = resp;
    assign goBusy = goFlag;
    assign serialPortEnabled = portEn;
    // Strap is taken once the synchroniser has settled after reset release
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            strapCnt <= 3'h0;
            strapTaken <= 1'b0;
            fastClk <= 1'b0;
            portEn <= 1'b1; // [RULE2]
        end else begin
            portEn <= ~portDisable; // [RULE2]
            if (!strapTaken) begin
                strapCnt <= strapCnt + 3'h1;
                if (strapCnt == STRAP_SETTLE_CYC) begin
                    strapTaken <= 1'b1;
                    fastClk <= strapSync; // [RULE19]
                end
            end
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            halfCnt <= 8'h00;
        end else if (state == S_IDLE || state == S_OPEN) begin
            halfCnt <= halfLoad;
        end else begin
            halfCnt <= tick ? halfLoad : halfCnt - 8'h01;
        end
    end
    // Pending request; a new request wins over consumption in the same cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pend <= 1'b0;
            pendAddr <= 24'h000000;
        end else if (reqValid & ~hit) begin
            pend <= 1'b1;
            pendAddr <= reqAddr;
        end else if (startBurst | contBurst | dropPend) begin
            pend <= 1'b0;
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            goFlag <= 1'b0;
        end else if (goSet) begin
            goFlag <= 1'b1;
        end else if (manEnd | goDrop) begin
            goFlag <= 1'b0; // [RULE20]
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            resp <= '0;
        end else if (manStart) begin
            resp <= '0;
        end else if (respWrite) begin
            resp[respIdx[2:0]] <= {shIn[6:0], inMiso}; // [RULE12] [RULE18]
        end
    end
    // Fetch cache: entries indexed by low address bits, so the window slides freely
    always_ff @(posedge clk) begin
        if (byteDone) cacheMem[curAddr[CIDX-1:0]] <= shIn; // [RULE9]
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cacheBase <= 24'h000000;
            cacheLen <= '0;
        end else if (manStart) begin
            // Erase or program may change flash contents behind the cache
            cacheLen <= '0;
        end else if (byteDone) begin
            if (jumpRun) begin
                cacheBase <= curAddr; // [RULE9]
                cacheLen <= (CIDX + 1)'(1);
            end else if (cacheLen == CACHE_FULL) begin
                cacheBase <= cacheBase + 24'h000001; // [RULE9]
            end else begin
                cacheLen <= cacheLen + (CIDX + 1)'(1);
            end
        end
    end
    // Boot signature check
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bootIdx <= 2'h0;
            bootWait <= 1'b0;
            bootDone <= 1'b0;
            externalBoot <= 1'b0;
        end else if (booting) begin
            if (!portEn) begin
                bootDone <= 1'b1;
            end else if (bootReq) begin
                bootWait <= 1'b1;
            end else if (bootWait && rsp.ready) begin
                bootWait <= 1'b0;
                bootIdx <= bootIdx + 2'h1;
                if (rsp.data != BOOT_SIG[bootIdx]) begin
                    bootDone <= 1'b1; // [RULE1]
                end else if (bootIdx == SIG_LAST) begin
                    bootDone <= 1'b1;
                    externalBoot <= 1'b1; // [RULE1]
                end
            end
        end
    end
    // Main serial sequencer, mode 0: data changes on falling edges, sampled on rising
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= S_IDLE;
            pins <= '{sck: 1'b0, csN: 1'b1, dataOut: 1'b0, dataOutOe: 1'b0};
            rsp <= '0;
            bitCnt <= 11'h000;
            shOut <= 40'h0;
            shIn <= 8'h00;
            curAddr <= 24'h000000;
            dualRun <= 1'b0;
            jumpRun <= 1'b0;
        end else begin
            rsp.ready <= 1'b0;
            if (hit) begin
                rsp.ready <= 1'b1;
                rsp.data <= cacheMem[reqAddr[CIDX-1:0]]; // [RULE10]
            end
            case (state)
                S_IDLE: begin
                    pins.sck <= 1'b0;
                    pins.csN <= 1'b1;
                    pins.dataOutOe <= 1'b0;
                    bitCnt <= 11'h000;
                    if (startBurst) begin
                        state <= S_HDR;
                        pins.csN <= 1'b0; // [RULE3]
                        pins.dataOut <= hdrWord[39];
                        pins.dataOutOe <= 1'b1;
                        shOut <= hdrWord;
                        curAddr <= pendAddr;
                        dualRun <= dualMode;
                        jumpRun <= 1'b1;
                    end else if (manStart) begin
                        state <= S_MAN;
                        pins.csN <= 1'b0; // [RULE11]
                        pins.dataOut <= commandBuffer[0][7]; // [RULE15] [RULE16] [RULE17] [RULE18]
                        pins.dataOutOe <= 1'b1;
                    end
                end
                S_HDR: begin
                    if (rise) begin
                        pins.sck <= 1'b1;
                    end else if (fall) begin
                        pins.sck <= 1'b0;
                        if (bitCnt == {5'h00, HDR_BITS - 6'h01}) begin
                            state <= S_DATA;
                            bitCnt <= 11'h000;
                            pins.dataOut <= 1'b0;
                            pins.dataOutOe <= ~dualRun; // [RULE8]
                        end else begin
                            bitCnt <= bitCnt + 11'h001;
                            shOut <= {shOut[38:0], 1'b0};
                            pins.dataOut <= shOut[38]; // [RULE3]
                        end
                    end
                end
                S_DATA: begin
                    if (rise) begin
                        pins.sck <= 1'b1;
                        shIn <= sampled; // [RULE8]
                    end else if (fall) begin
                        pins.sck <= 1'b0;
                        bitCnt <= bitCnt + 11'h001;
                        if (byteDone) begin
                            state <= S_OPEN;
                            bitCnt <= 11'h000;
                            rsp.ready <= 1'b1; // [RULE4]
                            rsp.data <= shIn;
                        end
                    end
                end
                S_OPEN: begin
                    pins.sck <= 1'b0;
                    if (!portEn || hit) begin
                        state <= S_END;
                        pins.csN <= 1'b1; // [RULE6]
                    end else if (pend) begin
                        if (seqNext) begin
                            state <= S_DATA; // [RULE5]
                            curAddr <= pendAddr;
                            jumpRun <= 1'b0;
                        end else begin
                            state <= S_END;
                            pins.csN <= 1'b1; // [RULE6]
                        end
                    end else if (goFlag) begin
                        state <= S_END;
                        pins.csN <= 1'b1;
                    end
                end
                S_MAN: begin
                    if (rise) begin
                        pins.sck <= 1'b1;
                        shIn <= {shIn[6:0], inMiso};
                    end else if (fall) begin
                        pins.sck <= 1'b0;
                        if (manEnd) begin
                            state <= S_END;
                            pins.csN <= 1'b1; // [RULE14]
                            pins.dataOutOe <= 1'b0;
                        end else begin
                            bitCnt <= nextIdx;
                            pins.dataOut <= manBit; // [RULE13]
                        end
                    end
                end
                S_END: begin
                    // Select stays high one half period between frames
                    pins.csN <= 1'b1;
                    pins.dataOutOe <= 1'b0;
                    if (tick) begin
                        state <= S_IDLE;
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end
endmodule

// File: dv/flash_model.sv
// Behavioural serial flash answering fast reads and manual commands
`timescale 1ns/100ps
module flash_model #(
    parameter logic [23:0] ID_CODE = 24'h5A6B7C // Arbitrary identification value
) (
    input logic clk,
    input logic sigOk,
    input logic sck,
    input logic csN,
    input logic dataOut,
    input logic dataOutOe,
    output logic soLine,
    output logic doLine
);
    import flash_fetch_pkg::*;
    int cnt = 0, frames = 0, hd = 8, n = 0;
    logic [7:0] op = 8'h00, sh = 8'h00, b = 8'h00;
    logic [23:0] frAddr = 24'h000000;
    logic [7:0] obuf [16];
    logic dual = 1'b0, drv = 1'b0, soDrv = 1'b0, ioDrv = 1'b0, pat = 1'b0;
    function automatic logic [7:0] memByte(input logic [23:0] a);
        if (a >= 24'h00FFFA && a <= 24'h00FFFD)
            return (sigOk || a != 24'h00FFFA) ? BOOT_SIG[a[1:0] - 2'h2] : 8'h00;
        return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h5A;
    endfunction
    function automatic logic [7:0] rspByte(input logic [7:0] o, input int k);
        if (o == 8'h9F && k < 3)
            return ID_CODE[23 - 8 * k -: 8];
        return 8'hC0 + k[7:0];
    endfunction
    always @(posedge clk) pat <= ~pat;
    always @(negedge csN) begin
        frames++;
        cnt = 0;
        drv = 1'b0;
    end
    always @(posedge sck) if (!csN) begin
        sh = {sh[6:0], dataOut};
        cnt++;
        if (cnt == 8) begin
            op = sh;
            dual = (sh == 8'h3B);
        end
        if (cnt > 8 && cnt <= 32) frAddr = {frAddr[22:0], dataOut};
        if (cnt % 8 == 0 && cnt <= 128) obuf[cnt / 8 - 1] = sh;
    end
    // Bits change after falling edges, settled for the rising sample
    always @(negedge sck) if (!csN) begin
        hd = (op == 8'h0B || op == 8'h3B) ? 40 : 8;
        if (cnt >= hd) begin
            n = cnt - hd;
            drv = 1'b1;
            if (hd == 8) begin
                b = rspByte(op, n / 8);
                soDrv = b[7 - n % 8];
            end else if (dual) begin
                b = memByte(frAddr + n / 4);
                {soDrv, ioDrv} = 2'(b >> (6 - 2 * (n % 4)));
            end else begin
                b = memByte(frAddr + n / 8);
                soDrv = b[7 - n % 8];
            end
        end
    end
    // Undriven lines toggle so stale values never pass as data
    assign soLine = (!csN && drv) ? soDrv : pat;
    assign doLine = dataOutOe ? dataOut : ((!csN && drv && dual) ? ioDrv : pat);
endmodule

// File: dv/serial_flash_fetch_controller_chk.sv
// Port-level assertions for the serial flash fetch controller
`timescale 1ns/100ps
module serial_flash_fetch_controller_chk
    import flash_fetch_pkg::*;
(
    input logic clk,
    input logic rst_n,
    input fetch_rsp_s fetchRsp,
    input logic portDisable,
    input logic flashSpeedStrap,
    input logic goSet,
    input byte_buf_t responseBuffer,
    input logic goBusy,
    input logic serialPortEnabled,
    input logic bootDone,
    input logic externalBoot,
    input flash_pins_s flashPins
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_ready_one_pulse: assert property (fetchRsp.ready |=> !fetchRsp.ready)
        else $error("ready too long");
    a_data_holds: assert property (!fetchRsp.ready |-> $stable(fetchRsp.data))
        else $error("data changed without ready");
    a_sck_idle_low: assert property (flashPins.csN |-> !flashPins.sck)
        else $error("clock high while deselected");
    a_fast_half: assert property ($rose(flashPins.sck) && flashSpeedStrap |->
        flashPins.sck [*5] ##1 !flashPins.sck) else $error("fast half period wrong");
    a_slow_half: assert property ($rose(flashPins.sck) && !flashSpeedStrap |->
        ##9 flashPins.sck ##1 !flashPins.sck) else $error("slow half period wrong");
    a_go_sets_busy: assert property (goSet |=> goBusy)
        else $error("go did not set busy");
    a_go_clear_cs: assert property ($fell(goBusy) |-> flashPins.csN)
        else $error("go cleared with select low");
    a_port_follows: assert property (serialPortEnabled == !$past(portDisable))
        else $error("port enable lags disable bit");
    a_disabled_quiet: assert property (!serialPortEnabled && flashPins.csN |=> flashPins.csN)
        else $error("frame started while disabled");
    a_rsp_hold: assert property (flashPins.csN && !goBusy |-> $stable(responseBuffer))
        else $error("response moved while idle");
    a_boot_order: assert property (!bootDone |-> !externalBoot)
        else $error("external boot before check done");
endmodule
bind serial_flash_fetch_controller serial_flash_fetch_controller_chk i_chk (.clk(clk), .rst_n(rst_n),
    .fetchRsp(fetchRsp), .portDisable(portDisable), .flashSpeedStrap(flashSpeedStrap), .goSet(goSet),
    .responseBuffer(responseBuffer), .goBusy(goBusy), .serialPortEnabled(serialPortEnabled),
    .bootDone(bootDone), .externalBoot(externalBoot), .flashPins(flashPins));

// File: dv/test_serial_flash_fetch_controller.sv
// Self-checking bench for the serial flash fetch controller
`timescale 1ns/100ps
module test_serial_flash_fetch_controller;
    import flash_fetch_pkg::*;
    localparam int LIMIT = 60000;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic fetchReq = 1'b0, dualMode = 1'b0, portDisable = 1'b0, goSet = 1'b0;
    logic [23:0] fetchAddr = 24'h000000;
    logic strap = 1'b1, sigOk = 1'b1;
    logic [7:0] cmdLen = 8'h00;
    byte_buf_t cmdBuf = '0;
    byte_buf_t rspBuf;
    fetch_rsp_s fetchRsp;
    flash_pins_s pins;
    logic goBusy, portOn, bootDone, extBoot, soLine, doLine;
    int mismatches = 0, compares = 0, cyc = 0;
    logic [31:0] rnd = 32'h7F3D;
    int cq[$], last = -2;
    bit open = 0;
    logic [7:0] ops [9] = '{8'h20, 8'h52, 8'hD8, 8'h02, 8'h00, 8'h00, 8'h9F, 8'h00, 8'h00};
    logic [7:0] lens [9] = '{8'h04, 8'h04, 8'h04, 8'h05, 8'h01, 8'h01, 8'h04, 8'h0A, 8'h00};
    serial_flash_fetch_controller i_serial_flash_fetch_controller (.clk, .rst_n, .fetchReq, .fetchAddr,
        .fetchRsp, .dualMode, .fastReadOpcode(8'h3B), .portDisable, .flashSpeedStrap(strap), .goSet,
        .commandLength(cmdLen), .commandBuffer(cmdBuf), .responseBuffer(rspBuf), .goBusy,
        .serialPortEnabled(portOn), .bootDone, .externalBoot(extBoot), .flashPins(pins),
        .flashDataOutIn(doLine), .serialInLine(soLine));
    flash_model i_flash_model (.clk, .sigOk, .sck(pins.sck), .csN(pins.csN), .dataOut(pins.dataOut),
        .dataOutOe(pins.dataOutOe), .soLine, .doLine);
    always #20 clk = ~clk;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task step;
        @(posedge clk);
        #1;
    endtask
    task chk(input string name, input logic [31:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task wrap_up;
        $display("Checks %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            mismatches++;
            wrap_up;
        end
    end
    task reboot(input logic st, input logic ok);
        rst_n = 1'b0;
        strap = st;
        sigOk = ok;
        repeat (10) step;
        rst_n = 1'b1;
        chk("portOn", portOn, 1);
    endtask
    task manual(input logic [7:0] op, input logic [7:0] len);
        int f0, k, n;
        bit run;
        logic [7:0] e;
        run = len != 0 && !portDisable;
        cmdLen = len;
        cmdBuf[0] = op;
        for (k = 1; k < 8; k++) begin
            rnd = lfsr(rnd);
            cmdBuf[k] = rnd[7:0];
        end
        f0 = i_flash_model.frames;
        goSet = 1'b1;
        step;
        goSet = 1'b0;
        for (n = 0; n < 3000 && goBusy !== 1'b0; n++) step;
        chk("frames", i_flash_model.frames - f0, run);
        if (run) begin
            chk("bits", i_flash_model.cnt, int'(len) * 8);
            chk("csN", pins.csN, 1);
            for (k = 0; k < len; k++) begin
                e = k < 8 ? cmdBuf[k] : 8'hFF;
                chk("cmdByte", i_flash_model.obuf[k], e);
            end
            for (k = 0; k < 8; k++) begin
                e = k < len - 1 ? i_flash_model.rspByte(op, k) : 8'h00;
                chk("rspByte", rspBuf[k], e);
            end
        end
    endtask
    task fetch(input logic [23:0] a);
        int f0, lat;
        bit hit, sq;
        logic [23:0] ea;
        hit = 0;
        foreach (cq[j]) if (cq[j] == a) hit = 1;
        sq = !hit && open && a == last + 1;
        ea = dualMode ? a & 24'h01FFFF : a;
        f0 = i_flash_model.frames;
        step;
        fetchAddr = a;
        fetchReq = 1'b1;
        step;
        fetchReq = 1'b0;
        for (lat = 1; lat < 3000 && fetchRsp.ready !== 1'b1; lat++) step;
        chk("data", fetchRsp.data, i_flash_model.memByte(ea));
        chk("hit", lat <= 2, hit);
        chk("frames", i_flash_model.frames - f0, !hit && !sq);
        if (!hit && !sq) begin
            chk("op", i_flash_model.op, dualMode ? 8'h3B : 8'h0B);
            chk("addr", i_flash_model.frAddr, ea);
        end
        if (sq && dualMode) chk("dualFast", lat < 60, 1);
        if (hit) open = 0;
        else begin
            if (!sq) cq.delete();
            cq.push_back(a);
            open = 1;
        end
        if (cq.size() > 32) void'(cq.pop_front());
        last = a;
    endtask
    initial begin
        int i, n, h;
        logic [23:0] b;
        reboot(1'b1, 1'b1);
        for (n = 0; n < 5000 && bootDone !== 1'b1; n++) step;
        chk("extBoot", extBoot, 1);
        chk("bootAddr", i_flash_model.frAddr, 24'h00FFFA);
        for (i = 0; i < 9; i++) begin
            rnd = lfsr(rnd);
            manual(ops[i] == 8'h00 ? rnd[7:0] & 8'h7E : ops[i], lens[i]);
        end
        rnd = lfsr(rnd);
        b = rnd[23:0] & 24'h7FFF00;
        for (i = 0; i < 40; i++) fetch(b + i);
        fetch(b + 20);
        fetch(b + 39);
        fetch(b + 7);
        fetch(b + 8);
        // Address bit 23 set so its forcing shows
        dualMode = 1'b1;
        rnd = lfsr(rnd);
        b = {rnd[23:8] | 16'h8000, 8'h10};
        for (i = 0; i < 4; i++) fetch(b + i);
        dualMode = 1'b0;
        portDisable = 1'b1;
        step;
        step;
        chk("portOn", portOn, 0);
        fetchReq = 1'b1;
        step;
        fetchReq = 1'b0;
        h = 0;
        repeat (300) begin
            step;
            if (fetchRsp.ready === 1'b1) h++;
        end
        chk("dropped", h, 0);
        manual(8'h0E, 8'h01);
        portDisable = 1'b0;
        step;
        reboot(1'b0, 1'b0);
        for (n = 0; n < 2000 && pins.sck !== 1'b1; n++) step;
        for (h = 0; pins.sck === 1'b1 && h < 50; h++) step;
        chk("slowHalf", h, 10);
        for (n = 0; n < 9000 && bootDone !== 1'b1; n++) step;
        chk("bootDone", bootDone, 1);
        chk("extBoot", extBoot, 0);
        wrap_up;
    end
endmodule
